//--- bcc_regs.svh
// Constants for the branch/call/clear execute block: encodings, field positions, reset values.
// Assumes 16-bit instruction words and a 21-bit byte program counter.
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH
`define BCC_OP_BRANCH_OV 8'hE4
`define BCC_OP_BRANCH_Z 8'hE0
`define BCC_OP_CALL_HI 7'h76
`define BCC_OP_CALL_2ND 4'hF
`define BCC_OP_CALL_ACC 16'h0014
`define BCC_OP_CLEAR_WDT 16'h0004
`define BCC_OP_CLEAR_F 7'h35
`define BCC_OP_COMP_F 6'h07
`define BCC_ACCESS_LIMIT 8'h5F
`define BCC_ACCESS_HI_BASE 4'hF
`define BCC_ZERO_BYTE 8'h00
`define BCC_PC_RESET 21'h000000
`define BCC_PC_STEP 21'h000002
`define BCC_CALL_RET_STEP 21'h000004
`define BCC_ST_N 4
`define BCC_ST_OV 3
`define BCC_ST_Z 2
`endif

//--- bcc_pkg.sv
// Types shared by the branch/call/clear execute block.
// Assumes bcc_regs.svh is included by each user that needs constants.
package bcc_pkg;
  typedef logic [20:0] bcc_pc_t;
  typedef logic [15:0] bcc_word_t;
  typedef enum logic [2:0] {
    BCC_EXEC = 3'b001,
    BCC_FLUSH = 3'b010,
    BCC_CALL2 = 3'b100
  } bcc_state_e;
endpackage

//--- bcc_sync.sv
// Two-flop synchroniser for levels from outside the clock domain.
// Assumes one clock; first flop feeds only the second.
`timescale 1ns/100ps
module bcc_sync (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;
  // ----------------------------------------
  // Sync chain
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // bcc_sync

//--- bcc_addr.sv
// File-operand address former: access bank, banked or indexed literal offset.
// Assumes 4-bit bank select and a 12-bit data address.
`timescale 1ns/100ps
`include "bcc_regs.svh"
module bcc_addr
  import bcc_pkg::*;
(
  input wire logic access_i,
  input wire logic ext_set_i,
  input wire logic [7:0] file_i,
  input wire logic [3:0] bank_i,
  input wire logic [11:0] index_base_i,
  output logic [11:0] addr_o,
  output logic indexed_o
);
  // ----------------------------------------
  // Address selection
  // ----------------------------------------
  // Low half of access bank maps to bank 0, upper to the SFR bank
  wire [11:0] access_addr = {(file_i[7] ? `BCC_ACCESS_HI_BASE : 4'h0), file_i};
  assign indexed_o = !access_i && ext_set_i && (file_i <= `BCC_ACCESS_LIMIT);
  assign addr_o = indexed_o ? index_base_i + {4'h0, file_i}
                : access_i ? {bank_i, file_i}
                : access_addr;
endmodule // bcc_addr

//--- bcc_exec.sv
// Execute stage for relative branches, calls, clear/complement file and clear watchdog.
// Assumes one instruction word per cycle from fetch, and single-cycle data memory read.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "bcc_regs.svh"
module bcc_exec
  import bcc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic ext_set_en_i,
  input wire logic [11:0] index_base_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [7:0] latch_high_i,
  input wire logic [7:0] latch_upper_i,
  output logic [20:0] prog_counter_o,
  output logic [11:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  output logic file_we_o,
  output logic [20:0] stack_push_data_o,
  output logic stack_push_o,
  output logic wdt_clear_o,
  output logic [7:0] accumulator_reg_o,
  output logic [7:0] status_o,
  output logic [3:0] bank_select_reg_o,
  output logic [7:0] accumulator_shadow_o,
  output logic [7:0] status_shadow_o,
  output logic [3:0] bank_select_shadow_o,
  output logic timeout_flag_o,
  output logic power_down_flag_o,
  output logic flush_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Sign-extend an 8-bit offset and double it into a byte step
  function automatic bcc_pc_t rel_step(input logic [7:0] n);
    rel_step = {{12{n[7]}}, n, 1'b0};
  endfunction

  // Flags N and Z for a byte result, other status bits kept
  function automatic logic [7:0] nz_flags(input logic [7:0] st, input logic [7:0] res);
    logic [7:0] s;
    s = st;
    s[`BCC_ST_N] = res[7];
    s[`BCC_ST_Z] = (res == `BCC_ZERO_BYTE);
    nz_flags = s;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  bcc_state_e state_r, state_nxt;
  bcc_pc_t pc_r, pc_nxt;
  logic [7:0] acc_r, acc_nxt, status_r, status_nxt;
  logic [3:0] bank_r;
  logic [7:0] acc_sh_r, acc_sh_nxt, status_sh_r, status_sh_nxt;
  logic [3:0] bank_sh_r, bank_sh_nxt;
  logic [7:0] call_lo_r;
  logic call_pc_r;
  bcc_pc_t call_ret_r;
  logic to_r, to_nxt, pd_r, pd_nxt;
  logic [11:0] faddr_r;
  logic [7:0] fwdata_r, fwdata_nxt;
  logic fwe_r, fwe_nxt;
  bcc_pc_t push_data_r, push_data_nxt;
  logic push_r, push_nxt, wdt_r, wdt_nxt, flush_r;
  logic ext_set_s;
  logic [11:0] faddr_w;

  // Mode strap crosses from outside: synchronise first
  bcc_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(ext_set_en_i),
    .q_o(ext_set_s)
  );

  bcc_addr u_addr (
    .access_i(instr_i[8]),
    .ext_set_i(ext_set_s),
    .file_i(instr_i[7:0]),
    .bank_i(bank_r),
    .index_base_i(index_base_i),
    .addr_o(faddr_w),
    .indexed_o()
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire go = instr_valid_i && (state_r == BCC_EXEC);
  wire is_bov = go && (instr_i[15:8] == `BCC_OP_BRANCH_OV);
  wire is_bz = go && (instr_i[15:8] == `BCC_OP_BRANCH_Z);
  wire is_call = go && (instr_i[15:9] == `BCC_OP_CALL_HI);
  wire is_call_via_accumulator = go && (instr_i == `BCC_OP_CALL_ACC);
  wire is_clear_watchdog = go && (instr_i == `BCC_OP_CLEAR_WDT);
  wire is_clear_file_reg = go && (instr_i[15:9] == `BCC_OP_CLEAR_F);
  wire is_complement_file_reg = go && (instr_i[15:10] == `BCC_OP_COMP_F);
  wire call2_ok = instr_valid_i && (state_r == BCC_CALL2) && (instr_i[15:12] == `BCC_OP_CALL_2ND);
  wire take_ov = is_bov && status_r[`BCC_ST_OV];
  wire take_z = is_bz && status_r[`BCC_ST_Z];
  wire [7:0] comp_w = ~file_rdata_i;
  // Address of the executing word is pc_r minus two; pc_r already points past it
  wire bcc_pc_t here_w = pc_r - `BCC_PC_STEP;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_nxt = BCC_EXEC;
    pc_nxt = instr_valid_i ? pc_r + `BCC_PC_STEP : pc_r;
    acc_nxt = acc_r;
    status_nxt = status_r;
    acc_sh_nxt = acc_sh_r;
    status_sh_nxt = status_sh_r;
    bank_sh_nxt = bank_sh_r;
    to_nxt = to_r;
    pd_nxt = pd_r;
    fwdata_nxt = `BCC_ZERO_BYTE;
    fwe_nxt = 1'b0;
    push_data_nxt = push_data_r;
    push_nxt = 1'b0;
    wdt_nxt = 1'b0;
    case (state_r)
      BCC_EXEC: begin
        if (take_ov || take_z) begin
          pc_nxt = pc_r + rel_step(instr_i[7:0]);
          state_nxt = BCC_FLUSH;
        end else if (is_call) begin
          state_nxt = BCC_CALL2;
        end else if (is_call_via_accumulator) begin
          push_data_nxt = pc_r;
          push_nxt = 1'b1;
          pc_nxt = {latch_upper_i[4:0], latch_high_i, acc_r};
          state_nxt = BCC_FLUSH;
        end else if (is_clear_file_reg) begin
          fwe_nxt = 1'b1;
          status_nxt[`BCC_ST_Z] = 1'b1;
        end else if (is_complement_file_reg) begin
          status_nxt = nz_flags(status_r, comp_w);
          if (instr_i[9]) begin
            fwdata_nxt = comp_w;
            fwe_nxt = 1'b1;
          end else begin
            acc_nxt = comp_w;
          end
        end else if (is_clear_watchdog) begin
          wdt_nxt = 1'b1;
          to_nxt = 1'b1;
          pd_nxt = 1'b1;
        end
      end
      BCC_CALL2: begin
        if (!instr_valid_i) begin
          state_nxt = BCC_CALL2;
        end else if (call2_ok) begin
          push_data_nxt = call_ret_r;
          push_nxt = 1'b1;
          pc_nxt = {instr_i[11:0], call_lo_r, 1'b0};
          if (call_pc_r) begin
            acc_sh_nxt = acc_r;
            status_sh_nxt = status_r;
            bank_sh_nxt = bank_r;
          end
          state_nxt = BCC_FLUSH;
        end
      end
      BCC_FLUSH: begin
        // Stale word behind the jump runs as a no-operation
        if (!instr_valid_i) begin
          state_nxt = BCC_FLUSH;
        end
      end
      default: begin
        state_nxt = BCC_EXEC;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= BCC_EXEC;
      pc_r <= `BCC_PC_RESET;
      acc_r <= `BCC_ZERO_BYTE;
      status_r <= `BCC_ZERO_BYTE;
      bank_r <= 4'h0;
      acc_sh_r <= `BCC_ZERO_BYTE;
      status_sh_r <= `BCC_ZERO_BYTE;
      bank_sh_r <= 4'h0;
      to_r <= 1'b1;
      pd_r <= 1'b1;
    end else if (ce_i) begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      status_r <= status_nxt;
      acc_sh_r <= acc_sh_nxt;
      status_sh_r <= status_sh_nxt;
      bank_sh_r <= bank_sh_nxt;
      to_r <= to_nxt;
      pd_r <= pd_nxt;
    end
  end

  // Call first word held for the second cycle; return is first word plus four
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      call_lo_r <= `BCC_ZERO_BYTE;
      call_pc_r <= 1'b0;
      call_ret_r <= `BCC_PC_RESET;
    end else if (ce_i && is_call) begin
      call_lo_r <= instr_i[7:0];
      call_pc_r <= instr_i[8];
      call_ret_r <= here_w + `BCC_CALL_RET_STEP;
    end
  end

  // Output strobes, registered: one cycle each, except flush held until a valid word arrives
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      faddr_r <= 12'h000;
      fwdata_r <= `BCC_ZERO_BYTE;
      fwe_r <= 1'b0;
      push_data_r <= `BCC_PC_RESET;
      push_r <= 1'b0;
      wdt_r <= 1'b0;
      flush_r <= 1'b0;
    end else if (ce_i) begin
      faddr_r <= faddr_w;
      fwdata_r <= fwdata_nxt;
      fwe_r <= fwe_nxt;
      push_data_r <= push_data_nxt;
      push_r <= push_nxt;
      wdt_r <= wdt_nxt;
      flush_r <= (state_nxt == BCC_FLUSH);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prog_counter_o = pc_r;
  assign file_addr_o = faddr_r;
  assign file_wdata_o = fwdata_r;
  assign file_we_o = fwe_r;
  assign stack_push_data_o = push_data_r;
  assign stack_push_o = push_r;
  assign wdt_clear_o = wdt_r;
  assign accumulator_reg_o = acc_r;
  assign status_o = status_r;
  assign bank_select_reg_o = bank_r;
  assign accumulator_shadow_o = acc_sh_r;
  assign status_shadow_o = status_sh_r;
  assign bank_select_shadow_o = bank_sh_r;
  assign timeout_flag_o = to_r;
  assign power_down_flag_o = pd_r;
  assign flush_o = flush_r;
endmodule // bcc_exec

//--- bcc_exec_assertions.sv
// Checker for the branch/call/clear execute block.
// Assumes it is bound to bcc_exec and sees only its ports.
`timescale 1ns/100ps
`include "bcc_regs.svh"
module bcc_exec_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [7:0] latch_high_i,
  input wire logic [7:0] latch_upper_i,
  input wire logic [20:0] prog_counter_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic file_we_o,
  input wire logic [20:0] stack_push_data_o,
  input wire logic stack_push_o,
  input wire logic wdt_clear_o,
  input wire logic [7:0] accumulator_reg_o,
  input wire logic [7:0] status_o,
  input wire logic timeout_flag_o,
  input wire logic power_down_flag_o,
  input wire logic flush_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Decode of the word taken this edge
  // ----------------------------------------
  wire take = ce_i && instr_valid_i && !flush_o;
  wire is_bz = take && instr_i[15:8] == `BCC_OP_BRANCH_Z;
  wire is_bov = take && instr_i[15:8] == `BCC_OP_BRANCH_OV;
  wire br_take = is_bz && status_o[`BCC_ST_Z] || is_bov && status_o[`BCC_ST_OV];
  wire br_fall = (is_bz || is_bov) && !br_take;
  wire [20:0] off2 = {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
  wire [1:0] comp_nz = {~file_rdata_i[7], file_rdata_i == 8'hFF};
  wire [20:0] call_via_accumulator_tgt = {latch_upper_i[4:0], latch_high_i, accumulator_reg_o};
  logic call1_r;
  logic [7:0] klo_r;
  wire [20:0] call_tgt = {instr_i[11:0], klo_r, 1'b0};
  // First call word remembered so the second can be judged
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      call1_r <= 1'b0;
      klo_r <= 8'h00;
    end else if (ce_i && instr_valid_i) begin
      call1_r <= take && instr_i[15:9] == `BCC_OP_CALL_HI;
      klo_r <= instr_i[7:0];
    end
  end
  chk_branch_jump: assert property (
    br_take |=> flush_o && prog_counter_o == $past(prog_counter_o) + $past(off2))
    else $error("taken branch target or flush wrong");
  chk_branch_fall: assert property (
    br_fall |=> !flush_o && prog_counter_o == $past(prog_counter_o) + 21'h2)
    else $error("untaken branch did not fall through");
  chk_call_target: assert property (
    call1_r && ce_i && instr_valid_i && instr_i[15:12] == `BCC_OP_CALL_2ND
    |=> flush_o && prog_counter_o == $past(call_tgt))
    else $error("call target wrong");
  chk_call_via_accumulator_push: assert property (
    take && instr_i == `BCC_OP_CALL_ACC
    |=> stack_push_o && flush_o && stack_push_data_o == $past(prog_counter_o)
    && prog_counter_o == $past(call_via_accumulator_tgt))
    else $error("call via accumulator wrong");
  chk_clear_file: assert property (
    take && instr_i[15:9] == `BCC_OP_CLEAR_F
    |=> file_we_o && file_wdata_o == 8'h00 && status_o[`BCC_ST_Z])
    else $error("clear file wrong");
  chk_wdt_clear: assert property (
    take && instr_i == `BCC_OP_CLEAR_WDT |=> wdt_clear_o && timeout_flag_o && power_down_flag_o)
    else $error("clear watchdog wrong");
  chk_comp_flags: assert property (
    take && instr_i[15:10] == `BCC_OP_COMP_F
    |=> {status_o[`BCC_ST_N], status_o[`BCC_ST_Z]} == $past(comp_nz))
    else $error("complement flags wrong");
  chk_flush_quiet: assert property (
    flush_o && ce_i && instr_valid_i |=> !file_we_o && !stack_push_o && !wdt_clear_o)
    else $error("discarded word changed state");
  cover property (br_take);
  cover property (call1_r && instr_valid_i);
  cover property (flush_o && instr_valid_i);
endmodule // bcc_exec_assertions

//--- bcc_data_mem.sv
// Data memory partner for the file operand port.
// Assumes access-bank operands, indexed by the operand byte.
`timescale 1ns/100ps
module bcc_data_mem (
  input wire logic ref_clk_i,
  input wire logic [15:0] instr_i,
  input wire logic [11:0] file_addr_i,
  input wire logic [7:0] file_wdata_i,
  input wire logic file_we_i,
  output logic [7:0] file_rdata_o
);
  logic [7:0] mem [256];
  // Each cell starts at its own address
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0];
    end
  end
  // Read is combinational on the word on the bus
  assign file_rdata_o = mem[instr_i[7:0]];
  always @(posedge ref_clk_i) begin
    if (file_we_i) begin
      mem[file_addr_i[7:0]] <= file_wdata_i;
    end
  end
endmodule // bcc_data_mem

//--- testbench.sv
// Testbench for bcc_exec with a data memory partner.
// Assumes a 50 MHz clock and one word offered per cycle.
`timescale 1ns/100ps
module testbench;
  import bcc_pkg::*;
  logic ref_clk_i, rst_i, valid, ce, ext_set;
  logic [15:0] instr;
  logic [7:0] lat_hi, lat_up, rdata, wdata, acc, st, acc_sh, st_sh;
  logic [3:0] bank_select_reg, bsr_sh;
  logic [11:0] faddr, ibase;
  logic [20:0] pc, pdata, p;
  logic we, push, wdt, tmo, pdn, flush;
  int fail_count, cmp_count, pushes, n, cycles;
  // ----------------------------------------
  // Design, partner and clock
  // ----------------------------------------
  bcc_exec i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .instr_i(instr), .instr_valid_i(valid),
    .ext_set_en_i(ext_set), .index_base_i(ibase), .file_rdata_i(rdata), .latch_high_i(lat_hi),
    .latch_upper_i(lat_up), .prog_counter_o(pc), .file_addr_o(faddr), .file_wdata_o(wdata), .file_we_o(we),
    .stack_push_data_o(pdata), .stack_push_o(push), .wdt_clear_o(wdt), .accumulator_reg_o(acc),
    .status_o(st), .bank_select_reg_o(bank_select_reg), .accumulator_shadow_o(acc_sh), .status_shadow_o(st_sh),
    .bank_select_shadow_o(bsr_sh), .timeout_flag_o(tmo), .power_down_flag_o(pdn), .flush_o(flush));
  bcc_data_mem i_mem (.ref_clk_i(ref_clk_i), .instr_i(instr), .file_addr_i(faddr), .file_wdata_i(wdata),
    .file_we_i(we), .file_rdata_o(rdata));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // Push count and hang guard
  always @(posedge ref_clk_i) begin
    pushes += (push === 1'b1);
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic op(input logic [15:0] w);
    instr <= w;
    valid <= 1'b1;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    valid = 1'b0;
    instr = 16'h0000;
    lat_hi = 8'h10;
    lat_up = 8'h00;
    ce = 1'b1;
    ext_set = 1'b0;
    ibase = 12'h300;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk(tmo, 1);
    chk(pdn, 1);
    op(16'h0004); chk(wdt, 1);
    $display("test watchdog done");
    op(16'h6A20); chk({we, wdata, st[2]}, 10'h201);
    chk(faddr, 12'h020);
    p = pc;
    op(16'hE0FD); chk(pc, p - 21'h6);
    chk(flush, 1);
    op(16'h6A21); chk(we, 0);
    $display("test clear and branch done");
    op(16'h1C30); chk(acc, 8'hCF);
    chk({st[4], st[2]}, 2'b10);
    p = pc;
    op(16'hE005); chk({flush, pc}, {1'b0, p + 21'h2});
    p = pc;
    op(16'hE410); chk({flush, pc}, {1'b0, p + 21'h2});
    op(16'h1EFF); chk({we, wdata, st[2]}, 10'h201);
    $display("test complement done");
    p = pc;
    n = pushes;
    op(16'hED34);
    op(16'hF123); chk(pc, 21'h024668);
    op(16'h0000); chk(pushes, n + 1);
    chk(pdata, p + 21'h2);
    chk({acc_sh, st_sh, bsr_sh}, {8'hCF, st, bank_select_reg});
    op(16'h1C40);
    op(16'hEC00);
    op(16'hF000); chk(pc, 21'h0);
    op(16'h0000); chk(acc_sh, 8'hCF);
    $display("test call done");
    p = pc;
    op(16'h0014); chk(pc, 21'h0010BF);
    chk({flush, pdata}, {1'b1, p});
    op(16'h6A22); chk(we, 0);
    $display("test call via accumulator done");
    // Call whose second word lacks its prefix is dropped: no push, no jump
    p = pc;
    n = pushes;
    op(16'hEC12);
    op(16'h0000);
    op(16'h0000); chk(pushes, n);
    chk({flush, pc}, {1'b0, p + 21'h6});
    // Clock enable low: offered clear is not taken
    p = pc;
    ce <= 1'b0;
    op(16'h6A05); chk({we, pc}, {1'b0, p});
    $display("test refusal and freeze done");
    // Extended set needs two edges through the synchroniser
    ce <= 1'b1;
    ext_set <= 1'b1;
    op(16'h0000);
    op(16'h0000);
    op(16'h6A5F); chk(faddr, 12'h35F);
    op(16'h6A60); chk(faddr, 12'h060);
    op(16'h6B90); chk(faddr, 12'h090);
    valid <= 1'b0;
    $display("test addressing done");
    end_sim();
  end
endmodule // testbench
bind bcc_exec bcc_exec_assertions i_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .instr_i(instr_i),
  .instr_valid_i(instr_valid_i), .file_rdata_i(file_rdata_i), .latch_high_i(latch_high_i),
  .latch_upper_i(latch_upper_i), .prog_counter_o(prog_counter_o), .file_wdata_o(file_wdata_o),
  .file_we_o(file_we_o), .stack_push_data_o(stack_push_data_o), .stack_push_o(stack_push_o),
  .wdt_clear_o(wdt_clear_o), .accumulator_reg_o(accumulator_reg_o), .status_o(status_o),
  .timeout_flag_o(timeout_flag_o), .power_down_flag_o(power_down_flag_o), .flush_o(flush_o));
